// [rtl/stot_pkg.sv]
// Package of constants for the sample timing and offset trim bank.
package stot_pkg;

  // ----------------------------------------------------------------------
  // Register word indices; offsets are not all multiples of four.
  // ----------------------------------------------------------------------
  localparam logic [11:0] CORE_A_DUAL_TIMING_TRIM_IDX           = 12'h310;
  localparam logic [11:0] CORE_B_DUAL_TIMING_TRIM_IDX           = 12'h313;
  localparam logic [11:0] CORE_A_SINGLE_INPUT_A_TIMING_TRIM_IDX = 12'h314;
  localparam logic [11:0] CORE_B_SINGLE_INPUT_A_TIMING_TRIM_IDX = 12'h315;
  localparam logic [11:0] CORE_A_SINGLE_INPUT_B_TIMING_TRIM_IDX = 12'h31a;
  localparam logic [11:0] CORE_B_SINGLE_INPUT_B_TIMING_TRIM_IDX = 12'h31b;
  localparam logic [11:0] CORE_A_DUAL_INPUT_A_OFFSET_TRIM_IDX   = 12'h344;
  localparam logic [11:0] TRIM_CONTROL_IDX                      = 12'h3f0;
  localparam logic [11:0] TRIM_STATUS_IDX                       = 12'h3f1;

  // ----------------------------------------------------------------------
  // Field layout and reset values.
  // ----------------------------------------------------------------------
  localparam int          TIMING_TRIM_W   = 8;
  localparam int          OFFSET_TRIM_W   = 12;
  localparam int          OFFSET_REG_W    = 16;
  localparam int          NUM_TIMING      = 6;
  localparam int          BYTE_SHIFT      = 2;
  localparam logic [7:0]  TIMING_RESET    = 8'h00;
  localparam logic [11:0] OFFSET_RESET    = 12'h000;
  localparam int          CTL_SINGLE_BIT  = 0;
  localparam int          CTL_INPUT_B_BIT = 1;
  localparam int          CTL_FG_CAL_BIT  = 2;
  localparam int          CTL_LOAD_BIT    = 3;
  localparam logic [3:0]  CTL_RESET       = 4'h0;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;

  // Operating case that decides which trims reach the cores.
  typedef enum logic [1:0] {STOT_DUAL, STOT_SINGLE_A, STOT_SINGLE_B} stot_case_e;

endpackage

// [rtl/stot_trim_bank.sv]
// Trim register bank with AHB-Lite slave and per-core trim selection.
// Function
// RULE1: Core A dual-mode 8-bit read/write timing trim sets its sampling instant.
// RULE2: Trims start from factory defaults; software reads them back and overwrites.
// RULE3: Core B 8-bit timing trim applies in dual mode with calibration enabled.
// RULE4: Core A 90-degree trim applies single mode, calibration on, input A.
// RULE5: Core B 0-degree trim applies single mode, calibration on, input A.
// RULE6: Core A 90-degree trim applies single mode, calibration on, input B.
// RULE7: Core B 0-degree trim applies single mode, calibration on, input B.
// RULE8: Core A 12-bit offset trim for dual mode input A; upper four bits reserved.
// RULE9: Each core receives only the trim matching mode, input and calibration state.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
module stot_trim_bank
  import stot_pkg::*;
#(
  parameter logic [7:0]  DEF_A_DUAL     = 8'h00,
  parameter logic [7:0]  DEF_B_DUAL     = 8'h00,
  parameter logic [7:0]  DEF_A_SINGLE_A = 8'h00,
  parameter logic [7:0]  DEF_B_SINGLE_A = 8'h00,
  parameter logic [7:0]  DEF_A_SINGLE_B = 8'h00,
  parameter logic [7:0]  DEF_B_SINGLE_B = 8'h00,
  parameter logic [11:0] DEF_OFFSET_A   = 12'h000
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [7:0]  core_a_timing,
  output      logic [7:0]  core_b_timing,
  output      logic [11:0] core_a_offset,
  output      logic        core_a_offset_valid
);

  // ----------------------------------------------------------------------
  // Bus address phase capture.
  // ----------------------------------------------------------------------
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [11:0] widx_r;
  logic [11:0] widx_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic [11:0] aidx;
  logic        acc;
  logic        default_pending_r;
  logic        default_pending_nxt;
  stot_case_e  sel_case;

  assign acc  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign aidx = haddr[BYTE_SHIFT +: 12];

  // ----------------------------------------------------------------------
  // Trim storage.
  // ----------------------------------------------------------------------
  logic [NUM_TIMING-1:0]   t_we;
  logic [7:0]              t_val [NUM_TIMING];
  logic [7:0]              t_def [NUM_TIMING];
  logic [11:0]             t_idx [NUM_TIMING];
  logic                    o_we;
  logic [11:0]             o_val;
  logic [3:0]              ctl_r;
  logic [3:0]              ctl_nxt;

  assign t_def[0] = DEF_A_DUAL;
  assign t_def[1] = DEF_B_DUAL;
  assign t_def[2] = DEF_A_SINGLE_A;
  assign t_def[3] = DEF_B_SINGLE_A;
  assign t_def[4] = DEF_A_SINGLE_B;
  assign t_def[5] = DEF_B_SINGLE_B;
  assign t_idx[0] = CORE_A_DUAL_TIMING_TRIM_IDX;
  assign t_idx[1] = CORE_B_DUAL_TIMING_TRIM_IDX;
  assign t_idx[2] = CORE_A_SINGLE_INPUT_A_TIMING_TRIM_IDX;
  assign t_idx[3] = CORE_B_SINGLE_INPUT_A_TIMING_TRIM_IDX;
  assign t_idx[4] = CORE_A_SINGLE_INPUT_B_TIMING_TRIM_IDX;
  assign t_idx[5] = CORE_B_SINGLE_INPUT_B_TIMING_TRIM_IDX;

  // Factory defaults load one cycle after reset release, or on request.
  logic load_default;
  assign load_default = default_pending_r || ctl_r[CTL_LOAD_BIT];

  // Timing trims, one instance each.
  for (genvar g = 0; g < NUM_TIMING; g++)
  begin : g_timing
    assign t_we[g] = wr_pend_r && (widx_r == t_idx[g]);
    stot_trim_reg #(.W(TIMING_TRIM_W)) u_reg
    (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .clk_en        (clk_en),
      .load_default  (load_default),
      .default_value (t_def[g]),
      .wr_en         (t_we[g]),
      .wr_data       (hwdata[7:0]),
      .value         (t_val[g])
    );
  end

  // Offset trim keeps only the low 12 bits; the reserved nibble reads zero.
  assign o_we = wr_pend_r && (widx_r == CORE_A_DUAL_INPUT_A_OFFSET_TRIM_IDX); // RULE8
  stot_trim_reg #(.W(OFFSET_TRIM_W)) u_offset
  (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .clk_en        (clk_en),
    .load_default  (load_default),
    .default_value (DEF_OFFSET_A),
    .wr_en         (o_we),
    .wr_data       (hwdata[11:0]),
    .value         (o_val)
  );

  // ----------------------------------------------------------------------
  // Bus control and read data.
  // ----------------------------------------------------------------------
  // Reads answer in the data phase with zero wait states; writes commit
  // at the end of the data phase, so a read right after sees the old value.
  always_comb
  begin
    wr_pend_nxt         = acc && hwrite;
    widx_nxt            = acc ? aidx : widx_r;
    default_pending_nxt = 1'b0;
    ctl_nxt             = ctl_r;
    ctl_nxt[CTL_LOAD_BIT] = 1'b0; // Load request is a self-clearing pulse.
    if (wr_pend_r && widx_r == TRIM_CONTROL_IDX)
    begin
      ctl_nxt = hwdata[3:0];
    end
    hrdata_nxt = hrdata_r;
    if (acc && !hwrite)
    begin
      hrdata_nxt = 32'h0000_0000;
      if (aidx == t_idx[0])
      begin
        hrdata_nxt[7:0] = t_val[0]; // RULE2
      end
      else if (aidx == t_idx[1])
      begin
        hrdata_nxt[7:0] = t_val[1];
      end
      else if (aidx == t_idx[2])
      begin
        hrdata_nxt[7:0] = t_val[2];
      end
      else if (aidx == t_idx[3])
      begin
        hrdata_nxt[7:0] = t_val[3];
      end
      else if (aidx == t_idx[4])
      begin
        hrdata_nxt[7:0] = t_val[4];
      end
      else if (aidx == t_idx[5])
      begin
        hrdata_nxt[7:0] = t_val[5];
      end
      else if (aidx == CORE_A_DUAL_INPUT_A_OFFSET_TRIM_IDX)
      begin
        hrdata_nxt[11:0] = o_val; // RULE8
      end
      else if (aidx == TRIM_CONTROL_IDX)
      begin
        hrdata_nxt[3:0] = ctl_r;
      end
      else if (aidx == TRIM_STATUS_IDX)
      begin
        hrdata_nxt[1:0] = sel_case;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Trim routing to the cores.
  // ----------------------------------------------------------------------
  logic [7:0]  a_nxt;
  logic [7:0]  b_nxt;
  logic [11:0] off_nxt;
  logic        offv_nxt;

  // Only the trim of the active case reaches a core; others wait stored.
  always_comb
  begin
    sel_case = ctl_r[CTL_SINGLE_BIT] ?
               (ctl_r[CTL_INPUT_B_BIT] ? STOT_SINGLE_B : STOT_SINGLE_A) : STOT_DUAL;
    a_nxt    = t_val[0];
    b_nxt    = t_val[1];
    off_nxt  = OFFSET_RESET;
    offv_nxt = 1'b0;
    case (sel_case) // RULE9
      STOT_DUAL:
      begin
        a_nxt    = t_val[0]; // RULE1
        b_nxt    = ctl_r[CTL_FG_CAL_BIT] ? t_val[1] : TIMING_RESET; // RULE3
        offv_nxt = ctl_r[CTL_FG_CAL_BIT] && !ctl_r[CTL_INPUT_B_BIT]; // RULE8
        off_nxt  = offv_nxt ? o_val : OFFSET_RESET;
      end
      STOT_SINGLE_A:
      begin
        a_nxt = ctl_r[CTL_FG_CAL_BIT] ? t_val[2] : TIMING_RESET; // RULE4
        b_nxt = ctl_r[CTL_FG_CAL_BIT] ? t_val[3] : TIMING_RESET; // RULE5
      end
      default:
      begin
        a_nxt = ctl_r[CTL_FG_CAL_BIT] ? t_val[4] : TIMING_RESET; // RULE6
        b_nxt = ctl_r[CTL_FG_CAL_BIT] ? t_val[5] : TIMING_RESET; // RULE7
      end
    endcase
  end

  // Register stage for bus state, control and core outputs.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r           <= 1'b0;
      widx_r              <= 12'h000;
      hrdata_r            <= 32'h0000_0000;
      ctl_r               <= CTL_RESET;
      default_pending_r   <= 1'b1;
      core_a_timing       <= TIMING_RESET;
      core_b_timing       <= TIMING_RESET;
      core_a_offset       <= OFFSET_RESET;
      core_a_offset_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend_r           <= wr_pend_nxt;
      widx_r              <= widx_nxt;
      hrdata_r            <= hrdata_nxt;
      ctl_r               <= ctl_nxt;
      default_pending_r   <= default_pending_nxt;
      core_a_timing       <= a_nxt;
      core_b_timing       <= b_nxt;
      core_a_offset       <= off_nxt;
      core_a_offset_valid <= offv_nxt;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  sequence s_wr_a_dual;
    clk_en && t_we[0];
  endsequence

  property p_rule1;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_a_dual ##1 (clk_en && !t_we[0] && !load_default && sel_case == STOT_DUAL)
      |=> core_a_timing == $past(hwdata[7:0], 2);
  endproperty
  a_rule1: assert property (p_rule1) else $error("core A dual trim not applied"); // RULE1

  property p_rule2;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && t_we[2] && !load_default) |=> t_val[2] == $past(hwdata[7:0]);
  endproperty
  a_rule2: assert property (p_rule2) else $error("trim write not stored"); // RULE2

  property p_rule3;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && sel_case == STOT_DUAL && ctl_r[CTL_FG_CAL_BIT])
      |=> core_b_timing == $past(t_val[1]);
  endproperty
  a_rule3: assert property (p_rule3) else $error("core B dual trim wrong"); // RULE3

  property p_rule4;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && sel_case == STOT_SINGLE_A && ctl_r[CTL_FG_CAL_BIT])
      |=> core_a_timing == $past(t_val[2]);
  endproperty
  a_rule4: assert property (p_rule4) else $error("core A single A trim wrong"); // RULE4

  property p_rule5;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && sel_case == STOT_SINGLE_A && ctl_r[CTL_FG_CAL_BIT])
      |=> core_b_timing == $past(t_val[3]);
  endproperty
  a_rule5: assert property (p_rule5) else $error("core B single A trim wrong"); // RULE5

  property p_rule6;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && sel_case == STOT_SINGLE_B && ctl_r[CTL_FG_CAL_BIT])
      |=> core_a_timing == $past(t_val[4]);
  endproperty
  a_rule6: assert property (p_rule6) else $error("core A single B trim wrong"); // RULE6

  property p_rule7;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && sel_case == STOT_SINGLE_B && ctl_r[CTL_FG_CAL_BIT])
      |=> core_b_timing == $past(t_val[5]);
  endproperty
  a_rule7: assert property (p_rule7) else $error("core B single B trim wrong"); // RULE7

  property p_rule8;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && acc && !hwrite && aidx == CORE_A_DUAL_INPUT_A_OFFSET_TRIM_IDX)
      |=> hrdata[31:12] == 20'h00000 && hrdata[11:0] == $past(o_val);
  endproperty
  a_rule8: assert property (p_rule8) else $error("offset trim readback wrong"); // RULE8

  // The offset reaches core A one cycle after its case is entered.
  property p_rule8_route;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && sel_case == STOT_DUAL && ctl_r[CTL_FG_CAL_BIT] && !ctl_r[CTL_INPUT_B_BIT])
      |=> core_a_offset_valid && core_a_offset == $past(o_val);
  endproperty
  a_rule8_route: assert property (p_rule8_route) else $error("offset trim not routed"); // RULE8

  property p_rule9;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && (sel_case != STOT_DUAL || !ctl_r[CTL_FG_CAL_BIT] || ctl_r[CTL_INPUT_B_BIT]))
      |=> !core_a_offset_valid && core_a_offset == OFFSET_RESET;
  endproperty
  a_rule9: assert property (p_rule9) else $error("offset routed outside its case"); // RULE9

endmodule // stot_trim_bank

// [rtl/stot_trim_reg.sv]
// One trim register with factory default load and software overwrite.
`timescale 1ns/1ns
module stot_trim_reg
#(
  parameter int W = 8
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         clk_en,
  input  wire logic         load_default,
  input  wire logic [W-1:0] default_value,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output      logic [W-1:0] value
);

  logic [W-1:0] value_r;
  logic [W-1:0] value_nxt;

  // A software write wins over a default load in the same cycle.
  always_comb
  begin
    value_nxt = value_r;
    if (load_default)
    begin
      value_nxt = default_value;
    end
    if (wr_en)
    begin
      value_nxt = wr_data;
    end
  end

  // Register stage.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      value_r <= '0;
    end
    else if (clk_en)
    begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;

endmodule // stot_trim_reg

// [tb/tb_stot_trim_bank.sv]
// Self-checking testbench for the sample timing and offset trim bank.
`timescale 1ns/1ns
module tb_stot_trim_bank;
  import stot_pkg::*;

  // ----------------------------------------------------------------------
  // Stimulus tables and factory defaults given to the bank.
  // ----------------------------------------------------------------------
  typedef struct {logic [11:0] idx; logic [31:0] wdata; logic [31:0] rexp; logic [31:0] dflt;}
    stot_reg_row_s;
  typedef struct {logic [3:0] ctl; logic [7:0] ea; logic [7:0] eb; logic [11:0] eo; logic ev;
    logic [1:0] ecase;} stot_mode_row_s;

  // Most defaults are non-zero so that a load can be told apart from a reset;
  // the two core B single-channel trims keep the bank's zero default.
  stot_reg_row_s  regs [7] = '{
    '{CORE_A_DUAL_TIMING_TRIM_IDX,           32'h0000_0011, 32'h11, 32'ha1},
    '{CORE_B_DUAL_TIMING_TRIM_IDX,           32'h0000_0022, 32'h22, 32'hb2},
    '{CORE_A_SINGLE_INPUT_A_TIMING_TRIM_IDX, 32'h0000_0033, 32'h33, 32'hc3},
    '{CORE_B_SINGLE_INPUT_A_TIMING_TRIM_IDX, 32'h0000_0044, 32'h44, 32'h00},
    '{CORE_A_SINGLE_INPUT_B_TIMING_TRIM_IDX, 32'h0000_0055, 32'h55, 32'he5},
    '{CORE_B_SINGLE_INPUT_B_TIMING_TRIM_IDX, 32'h0000_0066, 32'h66, 32'h00},
    '{CORE_A_DUAL_INPUT_A_OFFSET_TRIM_IDX,   32'hffff_fabc, 32'habc, 32'h789}};
  stot_mode_row_s modes [7] = '{
    '{4'h4, 8'h11, 8'h22, 12'habc, 1'b1, 2'h0},
    '{4'h0, 8'h11, 8'h00, 12'h000, 1'b0, 2'h0},
    '{4'h6, 8'h11, 8'h22, 12'h000, 1'b0, 2'h0},
    '{4'h5, 8'h33, 8'h44, 12'h000, 1'b0, 2'h1},
    '{4'h7, 8'h55, 8'h66, 12'h000, 1'b0, 2'h2},
    '{4'h1, 8'h00, 8'h00, 12'h000, 1'b0, 2'h1},
    '{4'h3, 8'h00, 8'h00, 12'h000, 1'b0, 2'h2}};

  logic        hclk        = 1'b0;
  logic        hresetn     = 1'b0;
  logic        clk_en      = 1'b1;
  logic        hsel        = 1'b0;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [2:0]  hsize       = 3'h2;
  logic [31:0] hwdata      = 32'h0;
  wire  logic  hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  core_a_timing;
  logic [7:0]  core_b_timing;
  logic [11:0] core_a_offset;
  logic        core_a_offset_valid;
  logic [31:0] rd;
  int          n_fail      = 0;
  int          check_count = 0;
  int          cycles      = 0;

  assign hready = hreadyout;

  stot_trim_bank #(
    .DEF_A_DUAL     (8'ha1),
    .DEF_B_DUAL     (8'hb2),
    .DEF_A_SINGLE_A (8'hc3),
    .DEF_A_SINGLE_B (8'he5),
    .DEF_OFFSET_A   (12'h789)
  ) dut (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .clk_en              (clk_en),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .core_a_timing       (core_a_timing),
    .core_b_timing       (core_b_timing),
    .core_a_offset       (core_a_offset),
    .core_a_offset_valid (core_a_offset_valid)
  );

  // ----------------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ----------------------------------------------------------------------
  initial
  begin
    forever #5 hclk = ~hclk;
  end

  // The whole run needs well under a thousand cycles, so this only trips on a hang.
  always @(posedge hclk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single word transfer; the master waits for hready at both phases, however long.
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] data);
    hsel   <= 1'b1;
    haddr  <= {18'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    data = hrdata;
  endtask

  task automatic check_regs(input logic use_dflt);
    foreach (regs[i])
    begin
      bus(1'b0, regs[i].idx, 32'h0, rd);
      check("trim readback", rd, use_dflt ? regs[i].dflt : regs[i].rexp);
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge hclk);
    check("core a timing in reset", {24'h0, core_a_timing}, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_regs(1'b1);
    $display("test factory defaults done");

    // Ordinary cases: every trim overwritten, then every operating case selected.
    foreach (regs[i])
      bus(1'b1, regs[i].idx, regs[i].wdata, rd);
    check_regs(1'b0);
    foreach (modes[i])
    begin
      bus(1'b1, TRIM_CONTROL_IDX, {28'h0, modes[i].ctl}, rd);
      repeat (3) @(posedge hclk);
      check("core a timing", {24'h0, core_a_timing}, {24'h0, modes[i].ea});
      check("core b timing", {24'h0, core_b_timing}, {24'h0, modes[i].eb});
      check("core a offset", {20'h0, core_a_offset}, {20'h0, modes[i].eo});
      check("offset valid", {31'h0, core_a_offset_valid}, {31'h0, modes[i].ev});
      bus(1'b0, TRIM_STATUS_IDX, 32'h0, rd);
      check("selected case", rd, {30'h0, modes[i].ecase});
      bus(1'b0, TRIM_CONTROL_IDX, 32'h0, rd);
      check("control readback", rd, {28'h0, modes[i].ctl});
    end
    $display("test mode selection done");

    // A trim written while its case runs with calibration off shows only once calibration is enabled.
    bus(1'b1, CORE_A_SINGLE_INPUT_B_TIMING_TRIM_IDX, 32'h0000_007e, rd);
    repeat (3) @(posedge hclk);
    check("idle trim hidden", {24'h0, core_a_timing}, 32'h0);
    bus(1'b1, TRIM_CONTROL_IDX, 32'h0000_0007, rd);
    repeat (3) @(posedge hclk);
    check("trim now routed", {24'h0, core_a_timing}, 32'h7e);
    $display("test deferred trim done");

    // Unmapped place reads zero and keeps nothing.
    bus(1'b1, 12'h3ff, 32'h1234_5678, rd);
    bus(1'b0, 12'h3ff, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    check("response okay", {31'h0, hresp}, 32'h0);
    check("ready high", {31'h0, hreadyout}, 32'h1);
    $display("test unmapped done");

    // With the clock enable low a write is not taken.
    clk_en <= 1'b0;
    bus(1'b1, CORE_B_DUAL_TIMING_TRIM_IDX, 32'h0000_0099, rd);
    clk_en <= 1'b1;
    bus(1'b0, CORE_B_DUAL_TIMING_TRIM_IDX, 32'h0, rd);
    check("frozen write", rd, 32'h22);
    $display("test clock enable done");

    // Reload pulse brings every trim back to its factory value.
    bus(1'b1, TRIM_CONTROL_IDX, 32'h0000_0008, rd);
    repeat (2) @(posedge hclk);
    check_regs(1'b1);
    $display("test reload done");

    // Mid-run reset clears outputs, and release loads the defaults again.
    // Every trim is overwritten first so that the reload after release shows.
    foreach (regs[i])
      bus(1'b1, regs[i].idx, regs[i].wdata, rd);
    bus(1'b1, TRIM_CONTROL_IDX, 32'h0000_0004, rd);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("core b in reset", {24'h0, core_b_timing}, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_regs(1'b1);
    $display("test second reset done");
    wrap_up();
  end

endmodule // tb_stot_trim_bank
